// ===== logic/gpt_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants and types for the periodic down timer and the
//          free running counter block.
// Assumes: pclk at 100 MHz, APB register access with 32-bit data.
// Notes:   Byte addresses of all registers live here.
//////////////////////////////////////////////////////////////////////////////
package gpt_pkg;

  // Clock rates and derived dividers
  localparam int CLK_MHZ       = 100;
  localparam int FRC_MHZ       = 25;
  localparam int CLK25_DIV     = CLK_MHZ / FRC_MHZ;
  localparam int TICK_US       = 100;
  localparam int TICK_CYC_25   = TICK_US * FRC_MHZ;
  localparam int FRC_CLEAR_NS  = 160;

  // Register byte addresses
  localparam logic [15:0] ADDR_TIMER_CONFIG  = 16'h008C;
  localparam logic [15:0] ADDR_TIMER_COUNT   = 16'h0090;
  localparam logic [15:0] ADDR_FREE_RUN      = 16'h009C;
  localparam logic [15:0] ADDR_IRQ_STATUS    = 16'h00A0;
  localparam logic [15:0] ADDR_IRQ_ENABLE    = 16'h00A4;
  localparam logic [15:0] ADDR_MAP_MODE      = 16'h00A8;
  localparam logic [15:0] ALIAS_OFFSET       = 16'h3000;

  // Field positions
  localparam int CFG_EN_BIT        = 29;
  localparam int CFG_PRELOAD_LSB   = 0;
  localparam int CFG_PRELOAD_MSB   = 15;
  localparam int WRAP_FLAG_BIT     = 0;
  localparam int MAP_MODE_BIT      = 0;

  // Reset values and the count wrap value
  localparam logic [15:0] PRELOAD_RST  = 16'hFFFF;
  localparam logic [15:0] COUNT_RST    = 16'hFFFF;
  localparam logic [15:0] COUNT_WRAP   = 16'hFFFF;
  localparam logic [31:0] FRC_RST      = 32'h0000_0000;
  localparam logic        EN_RST       = 1'b0;

  // Timer configuration as carried inside the block
  typedef struct packed {
    logic        en;
    logic [15:0] preload;
  } timer_config_t;

  // APB slave phases
  typedef enum logic [1:0] {
    GPT_ST_IDLE   = 2'b01,
    GPT_ST_ACCESS = 2'b10
  } gpt_apb_st_t;

endpackage

// ===== logic/gpt_timer_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Periodic 16-bit down timer with a 100 us tick and a 32-bit free
//          running counter at 25 MHz, reached over an APB slave.
// Assumes: pclk is 100 MHz; presetn is the chip-level reset.
// Notes:   One interrupt output, level, high while an unmasked flag is set.
//          The bus slave has no wait states: ready is a one-cycle pulse in
//          the first access cycle, and read data is captured at setup.
//          Both rate dividers run free from reset, so enabling the timer
//          does not restart the tick phase; the first step after enable
//          may come anywhere between one and a full tick period later.
//          The status, mask and address mode words sit beside the timer
//          registers here; a wider system may move them into its own
//          interrupt block and join only through the wrap flag.
//////////////////////////////////////////////////////////////////////////////
//
// Added by the designer: register access over APB.
module gpt_timer_top
  import gpt_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC_25,
  parameter int FRC_DIV  = CLK25_DIV
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [15:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Both helpers are pure; addr_hit serves three decoders and merge the config
  // write, which keeps the alias rule and the lane merge in one place each.

  // Address match at the base, or at the alias when alias mode is on
  function automatic logic addr_hit(input logic [15:0] addr,
                                    input logic [15:0] base,
                                    input logic        alias_on);
    logic [15:0] alt;
    alt      = base + ALIAS_OFFSET;
    addr_hit = (addr == base) || (alias_on && (addr == alt));
  endfunction

  // Byte-lane merge of write data into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  localparam int FDW = $clog2(FRC_DIV + 1);
  localparam int TDW = $clog2(TICK_DIV + 1);
  localparam logic [FDW-1:0] FRC_LAST  = FDW'(FRC_DIV - 1);
  localparam logic [TDW-1:0] TICK_LAST = TDW'(TICK_DIV - 1);

  gpt_apb_st_t     st_q;
  gpt_apb_st_t     st_d;
  timer_config_t        cfg_q;
  timer_config_t        cfg_d;
  logic [15:0]     count_q;
  logic [15:0]     count_d;
  logic [31:0]     frc_q;
  logic [FDW-1:0]  div25_q;
  logic [TDW-1:0]  pre_q;
  logic            wrap_flag_q;
  logic            wrap_flag_d;
  logic            wrap_en_q;
  logic            map_mode_q;
  logic [31:0]     prdata_q;
  logic            pready_q;
  logic            pslverr_q;
  logic            irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  // Only the three timer registers have an alias; the status, mask and mode
  // words answer at their base address alone. An address that matches
  // nothing is refused with an error and its write is dropped.
  // Decode is purely combinational on the held address, which the master
  // keeps steady from setup to the end of the access cycle.

  wire logic hit_cfg    = addr_hit(paddr, ADDR_TIMER_CONFIG, map_mode_q);
  wire logic hit_cnt    = addr_hit(paddr, ADDR_TIMER_COUNT, map_mode_q);
  wire logic hit_frc    = addr_hit(paddr, ADDR_FREE_RUN, map_mode_q);
  wire logic hit_sts    = (paddr == ADDR_IRQ_STATUS);
  wire logic hit_ien    = (paddr == ADDR_IRQ_ENABLE);
  wire logic hit_mode   = (paddr == ADDR_MAP_MODE);
  wire logic hit_any    = hit_cfg | hit_cnt | hit_frc | hit_sts | hit_ien | hit_mode;

  // Writes take effect only in the access cycle that completes the transfer
  wire logic setup_ph   = psel && !penable && (st_q == GPT_ST_IDLE);
  wire logic access_ph  = psel && penable && (st_q == GPT_ST_ACCESS);
  wire logic wr_go      = access_ph && pwrite && hit_any;
  wire logic wr_cfg     = wr_go && hit_cfg;
  wire logic wr_sts     = wr_go && hit_sts;
  wire logic wr_ien     = wr_go && hit_ien;
  wire logic wr_mode    = wr_go && hit_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Read data selection, reserved bits read as zero

  wire logic [31:0] cfg_word = {2'h0, cfg_q.en, 13'h0000, cfg_q.preload};
  wire logic [31:0] cnt_word = {16'h0000, count_q};
  wire logic [31:0] sts_word = {31'h0000_0000, wrap_flag_q};
  wire logic [31:0] ien_word = {31'h0000_0000, wrap_en_q};
  wire logic [31:0] mod_word = {31'h0000_0000, map_mode_q};

  wire logic [31:0] rd_word =
      hit_cfg  ? cfg_word :
      hit_cnt  ? cnt_word :
      hit_frc  ? frc_q    :
      hit_sts  ? sts_word :
      hit_ien  ? ien_word :
      hit_mode ? mod_word : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // APB phase tracking; the slave answers in the first access cycle
  // The phase state guards against a master that holds setup for more than
  // one cycle: a second setup edge is not taken until the access ends.
  // Back to back transfers are fine, since the access state always returns
  // to idle and a new setup can follow at once.

  always_comb begin
    st_d = st_q;
    case (st_q)
      GPT_ST_IDLE: begin
        if (setup_ph) begin
          st_d = GPT_ST_ACCESS;
        end
      end
      GPT_ST_ACCESS: begin
        st_d = GPT_ST_IDLE;
      end
      default: begin
        st_d = GPT_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= GPT_ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // Response flops: ready and data are prepared in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph && !hit_any;
      if (setup_ph && !pwrite) begin
        prdata_q <= rd_word;
      end else if (!setup_ph) begin
        prdata_q <= 32'h0000_0000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Rate dividers: 25 MHz enable from pclk, 100 us tick from 25 MHz
  // There is one clock only; the slower rates are single-cycle enables.
  // The tick is only issued together with the 25 MHz enable, so the timer
  // and the free running counter stay in step with each other.
  // A shortened tick divider is allowed for simulation; keep it above one.

  wire logic en25 = (div25_q == FRC_LAST);
  wire logic tick = en25 && (pre_q == TICK_LAST);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div25_q <= '0;
    end else if (en25) begin
      div25_q <= '0;
    end else begin
      div25_q <= div25_q + FDW'(1);
    end
  end

  // Prescaler runs free so the tick phase does not depend on enable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= '0;
    end else if (tick) begin
      pre_q <= '0;
    end else if (en25) begin
      pre_q <= pre_q + TDW'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Free running counter, never tied to any flag or interrupt

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frc_q <= FRC_RST;
    end else if (en25) begin
      frc_q <= frc_q + 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Timer configuration next value
  // Writes honour byte lanes, so a write that touches only the top byte
  // changes enable alone; the preload and the count change only by the load on a rise and the preload reset on a fall.
  // Reserved bits are never stored and always read back as zero.
  // The enable edges are seen on the write itself, not on the stored bit,
  // so the load and the preload reset happen in the same cycle as the write.

  wire logic [31:0] cfg_wr_word = merge(cfg_word, pwdata, pstrb);
  wire logic        new_en      = cfg_wr_word[CFG_EN_BIT];
  wire logic [15:0] new_preload = cfg_wr_word[CFG_PRELOAD_MSB:CFG_PRELOAD_LSB];
  wire logic        preload_wr  = wr_cfg && (pstrb[1:0] != 2'h0);
  wire logic        en_rise     = wr_cfg && new_en && !cfg_q.en;
  wire logic        en_fall     = wr_cfg && !new_en && cfg_q.en;

  always_comb begin
    cfg_d = cfg_q;
    if (wr_cfg) begin
      cfg_d.en      = new_en;
      cfg_d.preload = new_preload;
    end
    // Falling enable wins over a preload in the same write
    if (en_fall) begin
      cfg_d.preload = PRELOAD_RST;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q.en      <= EN_RST;
      cfg_q.preload <= PRELOAD_RST;
    end else begin
      cfg_q <= cfg_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Down counter: load on write or enable, otherwise step on tick
  // A load in the same cycle as a tick drops that step rather than stepping
  // the freshly loaded value; software then sees exactly what it wrote.
  // While disabled the count holds unless the preload is written, so a read shows where it was halted.
  // The count register ignores writes; only the preload field moves it.

  wire logic at_zero = (count_q == 16'h0000);
  wire logic wrap    = tick && cfg_q.en && at_zero && !preload_wr && !en_rise;

  always_comb begin
    count_d = count_q;
    if (preload_wr || en_rise) begin
      // A fresh value replaces any step due in this cycle
      count_d = new_preload;
    end else if (tick && cfg_q.en) begin
      if (at_zero) begin
        count_d = COUNT_WRAP;
      end else begin
        count_d = count_q - 16'h0001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q <= COUNT_RST;
    end else begin
      count_q <= count_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky wrap flag, its enable and the address mode bit
  // Set beats clear: a wrap that lands in the very cycle of a clearing write
  // must not be lost, or software would miss a whole period.
  // The mask does not gate the flag; a masked wrap is still recorded and
  // raises the line as soon as the mask bit is written to one.
  // The mode bit only opens the alias window; the base map always answers.

  always_comb begin
    wrap_flag_d = wrap_flag_q;
    if (wr_sts && pstrb[0] && pwdata[WRAP_FLAG_BIT]) begin
      wrap_flag_d = 1'b0;
    end
    // A wrap in the clearing cycle is kept
    if (wrap) begin
      wrap_flag_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wrap_flag_q <= 1'b0;
      wrap_en_q   <= 1'b0;
      map_mode_q  <= 1'b0;
    end else begin
      wrap_flag_q <= wrap_flag_d;
      if (wr_ien && pstrb[0]) begin
        wrap_en_q <= pwdata[WRAP_FLAG_BIT];
      end
      if (wr_mode && pstrb[0]) begin
        map_mode_q <= pwdata[MAP_MODE_BIT];
      end
    end
  end

  // Interrupt follows the next flag values, so it rises with the flag
  // Using the next values costs a little logic but keeps the line from
  // lagging the flag by a cycle after a wrap or an unmasking write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= wrap_flag_d && (wr_ien && pstrb[0] ? pwdata[WRAP_FLAG_BIT] : wrap_en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops
  // No output is a combinational function of a bus input, so the block
  // adds no path from the master's pins back to its own sampling flops.

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign irq     = irq_q;

endmodule

// ===== sim/gpt_timer_props.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Bus answer and interrupt checks at the timer block's ports.
// Assumes: Zero wait state slave; read data shows only in the access cycle.
// Notes:   The alias mode bit is hidden from here, so alias hits are not judged.
//////////////////////////////////////////////////////////////////////////////
module gpt_timer_props
  import gpt_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYC_25,
  parameter int FRC_DIV  = CLK25_DIV
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [15:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Address decode of the base map and of the alias window
  wire logic [15:0] alias_base = paddr - ALIAS_OFFSET;
  wire logic        base_hit   = paddr inside {ADDR_TIMER_CONFIG, ADDR_TIMER_COUNT, ADDR_FREE_RUN,
                                               ADDR_IRQ_STATUS, ADDR_IRQ_ENABLE, ADDR_MAP_MODE};
  wire logic        alias_hit  = alias_base inside {ADDR_TIMER_CONFIG, ADDR_TIMER_COUNT, ADDR_FREE_RUN};

  //////////////////////////////////////////////////////////////////////////////
  // Setup phase, then a read setup of one address
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read(logic [15:0] a);
    s_setup ##0 (!pwrite && paddr == a);
  endsequence

  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_idle_rdata_zero: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access");
  a_unmapped_err: assert property (s_setup ##0 (!base_hit && !alias_hit) |=> pslverr)
    else $error("unmapped address not refused");
  a_base_no_err: assert property (s_setup ##0 base_hit |=> !pslverr)
    else $error("base address refused");
  a_count_upper_zero: assert property (s_read(ADDR_TIMER_COUNT) |=> prdata[31:16] == 16'h0000)
    else $error("count upper bits not zero");
  a_cfg_reserved_zero: assert property (s_read(ADDR_TIMER_CONFIG) |=> prdata[31:30] == 2'h0 && prdata[28:16] == 13'h0000)
    else $error("config reserved bits not zero");
  // The level may only drop after a host write; a clear by itself is a fault
  a_irq_fall_by_write: assert property ($fell(irq) |-> $past(psel && penable && pwrite))
    else $error("interrupt dropped without a write");
endmodule

// ===== sim/gpt_timer_top_bench.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Self-checking bench for the down timer and free running counter.
// Assumes: Tick shortened to 3 x 4 = 12 cycles; free run steps every 4.
// Notes:   Reads spaced a multiple of 12 cycles apart make deltas exact.
//////////////////////////////////////////////////////////////////////////////
module gpt_timer_top_bench
  import gpt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [31:0] rdat;
  logic        rerr;
  logic [31:0] t0;
  int          n_mismatch;
  int          check_count;

  gpt_timer_top #(.TICK_DIV(3), .FRC_DIV(4)) gpt_timer_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

  // 100 MHz clock
  always #5 pclk = ~pclk;

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; waits an edge first so psel is never driven twice at once
  task automatic xfer(input logic [15:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rdat = prdata;
    rerr = pslverr;
    check("pready", 32'h1, 32'(pready));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check($sformatf("reg %h", a), exp, rdat);
  endtask

  task automatic tally_and_finish;
    $display("mismatches %0d checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #50us;
    n_mismatch++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    pstrb = 4'hF;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(ADDR_FREE_RUN, 32'h0000_0000);
    rd_chk(ADDR_TIMER_CONFIG, 32'h0000_FFFF);
    rd_chk(ADDR_TIMER_COUNT, 32'h0000_FFFF);
    xfer(ADDR_FREE_RUN, 1'b0, 32'h0);
    t0 = rdat;
    repeat (13) @(posedge pclk);
    xfer(ADDR_FREE_RUN, 1'b0, 32'h0);
    check("free run step", t0 + 32'h4, rdat);
    xfer(ADDR_TIMER_CONFIG, 1'b1, 32'h0000_0020);
    rd_chk(ADDR_TIMER_COUNT, 32'h0000_0020);
    repeat (21) @(posedge pclk);
    rd_chk(ADDR_TIMER_COUNT, 32'h0000_0020);
    xfer(ADDR_TIMER_COUNT, 1'b1, 32'h0000_1234);
    rd_chk(ADDR_TIMER_COUNT, 32'h0000_0020);
    xfer(ADDR_TIMER_CONFIG, 1'b1, 32'h2000_0005);
    xfer(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    t0 = rdat;
    check("count load", 32'h1, 32'(rdat == 32'h5 || rdat == 32'h4));
    repeat (21) @(posedge pclk);
    xfer(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    check("count step", t0 - 32'h2, rdat);
    // Unmasked wrap must raise the level within a few ticks
    xfer(ADDR_IRQ_ENABLE, 1'b1, 32'h0000_0001);
    for (int n = 0; n < 100 && irq !== 1'b1; n++) @(posedge pclk);
    check("irq wrap", 32'h1, 32'(irq));
    xfer(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    check("count wrap", 32'h1, 32'(rdat >= 32'h0000_FFFD && rdat <= 32'h0000_FFFF));
    rd_chk(ADDR_IRQ_STATUS, 32'h0000_0001);
    xfer(ADDR_IRQ_STATUS, 1'b1, 32'h0000_0000);
    rd_chk(ADDR_IRQ_STATUS, 32'h0000_0001);
    xfer(ADDR_IRQ_STATUS, 1'b1, 32'h0000_0001);
    rd_chk(ADDR_IRQ_STATUS, 32'h0000_0000);
    check("irq clear", 32'h0, 32'(irq));
    // Disable must force the preload and freeze the count
    xfer(ADDR_TIMER_CONFIG, 1'b1, 32'h0000_0007);
    rd_chk(ADDR_TIMER_CONFIG, 32'h0000_FFFF);
    xfer(ADDR_TIMER_COUNT, 1'b0, 32'h0);
    t0 = rdat;
    repeat (21) @(posedge pclk);
    rd_chk(ADDR_TIMER_COUNT, t0);
    // Masked wrap sets the flag but keeps the line low
    xfer(ADDR_IRQ_ENABLE, 1'b1, 32'h0000_0000);
    xfer(ADDR_TIMER_CONFIG, 1'b1, 32'h2000_0000);
    repeat (30) @(posedge pclk);
    check("irq masked", 32'h0, 32'(irq));
    rd_chk(ADDR_IRQ_STATUS, 32'h0000_0001);
    xfer(ADDR_IRQ_ENABLE, 1'b1, 32'h0000_0001);
    @(posedge pclk);
    check("irq unmask", 32'h1, 32'(irq));
    xfer(ADDR_IRQ_STATUS, 1'b1, 32'h0000_0001);
    // Unmapped and alias decode
    xfer(16'h0004, 1'b0, 32'h0);
    check("unmapped err", 32'h1, 32'(rerr));
    xfer(ADDR_TIMER_CONFIG + ALIAS_OFFSET, 1'b0, 32'h0);
    check("alias off err", 32'h1, 32'(rerr));
    xfer(ADDR_MAP_MODE, 1'b1, 32'h0000_0001);
    rd_chk(ADDR_TIMER_CONFIG + ALIAS_OFFSET, 32'h2000_0000);
    check("alias on err", 32'h0, 32'(rerr));
    tally_and_finish();
  end
endmodule

bind gpt_timer_top gpt_timer_props #(.TICK_DIV(TICK_DIV), .FRC_DIV(FRC_DIV)) gpt_timer_props_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
